// [hdl/dsm_consts.vh]
// Constants for the drive power-stage state machine of one axis.
// Assumes inclusion by the design files of the dsm block only.
// Operation
// R1: State follows command word, reported in status
// R2: Excite only in enabled, quick stop, reaction
// R3: Refuse parameter writes during initialization
// R4: Command word bit layout as fixed below
// R5: Shutdown, disable voltage, quick stop, reset edge
// R6: 0111 switch on, 1111 enable operation
// R7: Switch on needs comm, power, release off
// R8: Power-up enters not ready to switch on
// R9: Initialization done moves to switch on disabled
// R10: Quick stop at rest may go disabled
// R11: Alarm enters fault reaction, then fault
// R12: Condition loss while stopped drops to ready
// R13: Comm loss in motion raises alarm 81h
// R14: Power loss in motion raises alarm 23h
// R15: Release in motion goes ready, no alarm
// R16: Quick stop conditions lead to switch on disabled
// R17: Status bits six to zero per state
// R18: Voltage enabled bit follows main power
// R19: One evaluation per cycle, alarm wins
// R20: Fault reset only in fault, clears alarm
`ifndef DSM_CONSTS_VH
`define DSM_CONSTS_VH
`define DSM_CMD_OFFSET     16'h6040
`define DSM_STAT_OFFSET    16'h6041
`define DSM_CMD_RESET      16'h0000
`define DSM_CMD_SWITCH_ON  0
`define DSM_CMD_EN_VOLT    1
`define DSM_CMD_QSTOP      2
`define DSM_CMD_EN_OP      3
`define DSM_CMD_FAULT_RST  7
`define DSM_CMD_HALT       8
`define DSM_ST_READY       0
`define DSM_ST_SWITCHED    1
`define DSM_ST_OP_EN       2
`define DSM_ST_FAULT       3
`define DSM_ST_VOLT        4
`define DSM_ST_QSTOP       5
`define DSM_ST_SOD         6
`define DSM_ALM_NONE       8'h00
`define DSM_ALM_BUS        8'h81
`define DSM_ALM_POWER      8'h23
`endif

// [hdl/dsm_sync.v]
// Two-flip-flop synchroniser for a group of level inputs.
// Assumes the inputs are asynchronous pins; the reset is already synchronous-released.
`timescale 1ns/1ps
`default_nettype none
module dsm_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta_r;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= {W{1'b0}};
			q      <= {W{1'b0}};
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // dsm_sync
`default_nettype wire

// [hdl/dsm_top.v]
// Drive power-stage state machine for one axis, with the command and status words.
// Assumes the command port is driven synchronously to clk; condition pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "dsm_consts.vh"
module dsm_top (
	input  wire        clk,
	input  wire        rst_b,
	input  wire        cmd_wr,
	input  wire [15:0] cmd_addr,
	input  wire [15:0] cmd_wdata,
	input  wire [15:0] rd_addr,
	output reg  [15:0] rd_data,
	input  wire        comm_operational_state,
	input  wire        main_power,
	input  wire        release_in,
	input  wire        motor_moving,
	input  wire        init_done,
	input  wire        qstop_to_disabled,
	input  wire        param_wr,
	output reg         param_wr_ok,
	output reg         param_wr_refused,
	output reg         motor_excite,
	output reg         stop_request,
	output reg  [7:0]  alarm_code,
	output reg  [15:0] status_word
);
	// ****************************************
	// States
	// ****************************************
	localparam [7:0] S_NRDY = 8'h01;
	localparam [7:0] S_SOD  = 8'h02;
	localparam [7:0] S_RDY  = 8'h04;
	localparam [7:0] S_SWON = 8'h08;
	localparam [7:0] S_OPEN = 8'h10;
	localparam [7:0] S_QSA  = 8'h20;
	localparam [7:0] S_FRA  = 8'h40;
	localparam [7:0] S_FLT  = 8'h80;

	// ****************************************
	// Reset and input synchronisation
	// ****************************************
	reg rst_m_r;
	reg rst_s_r;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_m_r <= 1'b0;
			rst_s_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_s_r <= rst_m_r;
		end
	end

	wire [4:0] pins_s;
	dsm_sync #(.W(5)) u_sync (
		.clk   (clk),
		.rst_b (rst_s_r),
		.d     ({comm_operational_state, main_power, release_in, motor_moving, qstop_to_disabled}),
		.q     (pins_s)
	);
	wire comm_ok  = pins_s[4];
	wire power_ok = pins_s[3];
	wire rel_on   = pins_s[2];
	wire moving   = pins_s[1];
	wire qs_dis   = pins_s[0];
	// The release pin is active high: a one means the motor is released.
	wire cond_ok  = comm_ok & power_ok & ~rel_on;

	// ****************************************
	// Command word register
	// ****************************************
	reg [15:0] cmd_r;
	reg        frst_prev_r;
	always @(posedge clk or negedge rst_s_r) begin
		if (!rst_s_r) begin
			cmd_r       <= `DSM_CMD_RESET;
			frst_prev_r <= 1'b0;
		end else begin
			// R1: command capture
			if (cmd_wr && cmd_addr == `DSM_CMD_OFFSET) begin
				cmd_r <= cmd_wdata;
			end
			frst_prev_r <= cmd_r[`DSM_CMD_FAULT_RST];
		end
	end

	// R4: command field decode
	wire       b_son  = cmd_r[`DSM_CMD_SWITCH_ON];
	wire       b_ev   = cmd_r[`DSM_CMD_EN_VOLT];
	wire       b_qs   = cmd_r[`DSM_CMD_QSTOP];
	wire       b_eo   = cmd_r[`DSM_CMD_EN_OP];
	// R5: command pattern decode
	wire       c_shut = b_qs & b_ev & ~b_son;
	wire       c_dv   = ~b_ev;
	wire       c_qs   = ~b_qs & b_ev;
	wire       c_frst = cmd_r[`DSM_CMD_FAULT_RST] & ~frst_prev_r;
	// R6: switch on and enable operation
	wire       c_son  = ~b_eo & b_qs & b_ev & b_son;
	wire       c_eo   = b_eo & b_qs & b_ev & b_son;

	// ****************************************
	// State machine
	// ****************************************
	reg [7:0] state_r;
	reg [7:0] state_nxt;
	reg [7:0] alarm_r;
	reg [7:0] alarm_nxt;

	always @* begin
		state_nxt = state_r;
		alarm_nxt = alarm_r;
		case (state_r)
			// R8: power-up state
			S_NRDY: begin
				// R9: initialization complete
				if (init_done) begin
					state_nxt = S_SOD;
				end
			end
			S_SOD: begin
				if (c_shut) begin
					state_nxt = S_RDY;
				end
			end
			S_RDY: begin
				if (c_dv || c_qs) begin
					state_nxt = S_SOD;
				end else if ((c_son || c_eo) && cond_ok) begin
					// R7: switch on gated by conditions
					// R6: enable operation bypasses switched on
					state_nxt = c_eo ? S_OPEN : S_SWON;
				end
			end
			S_SWON: begin
				// R12: condition loss while stopped
				if (!cond_ok) begin
					state_nxt = S_RDY;
				end else if (c_dv || c_qs) begin
					state_nxt = S_SOD;
				end else if (c_shut) begin
					state_nxt = S_RDY;
				end else if (c_eo) begin
					state_nxt = S_OPEN;
				end
			end
			S_OPEN: begin
				// R19: alarm before commands
				if (moving && !comm_ok) begin
					// R13: bus error alarm
					alarm_nxt = `DSM_ALM_BUS;
					state_nxt = S_FRA;
				end else if (moving && !power_ok) begin
					// R14: power off alarm
					alarm_nxt = `DSM_ALM_POWER;
					state_nxt = S_FRA;
				end else if (!cond_ok) begin
					// R15: release in motion, no alarm
					// R12: condition loss while stopped
					state_nxt = S_RDY;
				end else if (c_dv) begin
					state_nxt = S_SOD;
				end else if (c_qs) begin
					state_nxt = S_QSA;
				end else if (c_shut) begin
					state_nxt = S_RDY;
				end else if (c_son) begin
					state_nxt = S_SWON;
				end
			end
			S_QSA: begin
				if (moving && !comm_ok) begin
					// R13: bus error alarm
					alarm_nxt = `DSM_ALM_BUS;
					state_nxt = S_FRA;
				end else if (moving && !power_ok) begin
					// R14: power off alarm
					alarm_nxt = `DSM_ALM_POWER;
					state_nxt = S_FRA;
				end else if (!cond_ok) begin
					// R16: quick stop to disabled
					state_nxt = S_SOD;
				end else if (c_dv) begin
					state_nxt = S_SOD;
				end else if (!moving && qs_dis) begin
					// R10: quick stop completion
					state_nxt = S_SOD;
				end else if (c_eo) begin
					state_nxt = S_OPEN;
				end
			end
			S_FRA: begin
				// R11: stop completed, enter fault
				if (!moving) begin
					state_nxt = S_FLT;
				end
			end
			S_FLT: begin
				// R20: fault reset edge
				if (c_frst) begin
					state_nxt = S_SOD;
					alarm_nxt = `DSM_ALM_NONE;
				end
			end
			default: begin
				state_nxt = S_NRDY;
				alarm_nxt = `DSM_ALM_NONE;
			end
		endcase
	end

	// ****************************************
	// Status word encoding
	// ****************************************
	reg [15:0] stat_nxt;
	always @* begin
		stat_nxt = 16'h0000;
		// R17: status bits per state
		case (state_nxt)
			S_FLT:  stat_nxt[6:0] = 7'h28;
			S_FRA:  stat_nxt[6:0] = 7'h2f;
			S_SOD:  stat_nxt[6:0] = 7'h60;
			S_RDY:  stat_nxt[6:0] = 7'h21;
			S_SWON: stat_nxt[6:0] = 7'h23;
			S_OPEN: stat_nxt[6:0] = 7'h27;
			S_QSA:  stat_nxt[6:0] = 7'h07;
			default: stat_nxt[6:0] = 7'h00;
		endcase
		// R18: voltage enabled from power
		stat_nxt[`DSM_ST_VOLT] = power_ok;
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	// The read port is registered, so a read returns data one cycle after the address.
	always @(posedge clk or negedge rst_s_r) begin
		if (!rst_s_r) begin
			state_r          <= S_NRDY;
			alarm_r          <= `DSM_ALM_NONE;
			status_word      <= 16'h0000;
			motor_excite     <= 1'b0;
			stop_request     <= 1'b0;
			alarm_code       <= `DSM_ALM_NONE;
			param_wr_ok      <= 1'b0;
			param_wr_refused <= 1'b0;
			rd_data          <= 16'h0000;
		end else begin
			// R19: one evaluation per cycle
			state_r      <= state_nxt;
			alarm_r      <= alarm_nxt;
			// R1: status reported
			status_word  <= stat_nxt;
			// R2: excitation per state
			motor_excite <= (state_nxt == S_OPEN) || (state_nxt == S_QSA) || (state_nxt == S_FRA);
			// R11: stop the operation
			stop_request <= (state_nxt == S_QSA) || (state_nxt == S_FRA);
			alarm_code   <= alarm_nxt;
			// R3: parameter write gating
			param_wr_ok      <= param_wr && (state_r != S_NRDY);
			param_wr_refused <= param_wr && (state_r == S_NRDY);
			if (rd_addr == `DSM_CMD_OFFSET) begin
				rd_data <= cmd_r;
			end else if (rd_addr == `DSM_STAT_OFFSET) begin
				rd_data <= status_word;
			end else begin
				rd_data <= 16'h0000;
			end
		end
	end
endmodule // dsm_top
`default_nettype wire

// [test/dsm_chk.sv]
// Assertions on the dsm_top ports.
// Assumes a bind from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module dsm_chk (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [15:0] rd_addr,
	input wire logic [15:0] rd_data,
	input wire logic        main_power,
	input wire logic        param_wr,
	input wire logic        param_wr_ok,
	input wire logic        param_wr_refused,
	input wire logic        motor_excite,
	input wire logic        stop_request,
	input wire logic [7:0]  alarm_code,
	input wire logic [15:0] status_word
);
	logic [2:0] age_r;
	wire        live;
	// The internal reset and the pin synchronisers lag rst_b, so history is trusted late.
	assign live = age_r == 3'h7;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			age_r <= 3'h0;
		else if (!live)
			age_r <= age_r + 3'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_EXCITE: assert property (live |-> motor_excite == (status_word[2:0] == 3'h7))
		else $error("excitation does not match state");
	AST_REACT: assert property (status_word[3:0] == 4'hf |-> stop_request && motor_excite)
		else $error("reaction state without stop");
	AST_VOLT: assert property (live |-> status_word[4] == $past(main_power, 3))
		else $error("voltage bit does not follow power");
	AST_RSV: assert property (live |-> status_word[15:7] == 9'h000)
		else $error("upper status bits set");
	AST_PARAM: assert property (live && param_wr |=> param_wr_ok != param_wr_refused)
		else $error("parameter write unanswered");
	AST_REFUSE: assert property (param_wr_refused |-> $past(status_word[6:5]) == 2'h0 && $past(status_word[3:0]) == 4'h0)
		else $error("parameter write refused after init");
	AST_ALARM: assert property ($rose(|alarm_code) |-> status_word[3:0] == 4'hf && $past(status_word[2:0]) == 3'h7)
		else $error("alarm raised outside motion");
	AST_ALHOLD: assert property (|alarm_code |-> status_word[3])
		else $error("alarm held outside fault");
	AST_READ: assert property (live && $past(rd_addr) == 16'h6041 |-> rd_data == $past(status_word))
		else $error("status read mismatch");
	AST_RDNONE: assert property (live && $past(rd_addr) != 16'h6040 && $past(rd_addr) != 16'h6041 |-> rd_data == 16'h0000)
		else $error("unmapped read not zero");
endmodule // dsm_chk
`default_nettype wire

// [test/dsm_master.sv]
// Fieldbus master model writing command words.
// Assumes writes are made one at a time from the bench.
`timescale 1ns/1ps
`default_nettype none
module dsm_master (
	input  wire logic        clk,
	output var  logic        cmd_wr,
	output var  logic [15:0] cmd_addr,
	output var  logic [15:0] cmd_wdata
);
	initial begin
		cmd_wr = 1'b0;
		cmd_addr = 16'h6040;
		cmd_wdata = 16'h0000;
	end
	// command patterns, reserved and mode bits randomised
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		cmd_wr = 1'b1;
		cmd_addr = a;
		cmd_wdata = d | (16'($urandom) & 16'hfe70);
		@(negedge clk);
		cmd_wr = 1'b0;
		cmd_wdata = ~cmd_wdata;
	endtask
endmodule // dsm_master
`default_nettype wire

// [test/dsm_top_tb.sv]
// Self-checking bench for dsm_top.
// Assumes dsm_master and dsm_chk are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dsm_top_tb;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cmd_wr, ok, rfs, exc, stp;
	logic [15:0] cmd_addr, cmd_wdata, rd_data, status_word;
	logic [15:0] rd_addr = 16'h6041;
	logic        comm = 1'b1, pwr = 1'b1, rel = 1'b0, mov = 1'b0, init = 1'b0, qsd = 1'b0, pw = 1'b0;
	logic [7:0]  alm;
	int          n_errors = 0, checks = 0, cyc = 0;
	logic [23:0] q[$];
	event        look;
	always #5 clk = ~clk;
	dsm_master M (.clk(clk), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
	dsm_top DUT (.clk(clk), .rst_b(rst_b), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.rd_addr(rd_addr), .rd_data(rd_data), .comm_operational_state(comm), .main_power(pwr),
		.release_in(rel), .motor_moving(mov), .init_done(init), .qstop_to_disabled(qsd), .param_wr(pw),
		.param_wr_ok(ok), .param_wr_refused(rfs), .motor_excite(exc), .stop_request(stp),
		.alarm_code(alm), .status_word(status_word));
	task chk(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t seen %h, expected %h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task s(input logic [23:0] e);
		repeat (6) @(negedge clk);
		q.push_back(e);
		-> look;
	endtask
	task p(input logic [1:0] e);
		pw = 1'b1;
		@(negedge clk) pw = 1'b0;
		chk({22'h000000, ok, rfs}, {22'h000000, e});
	endtask
	always @(look) chk({alm, status_word}, q.pop_front());
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			end_of_test;
		end
	end
	always @(negedge clk) rd_addr <= $urandom_range(1) ? 16'h6041 : 16'($urandom);
	initial begin
		void'($urandom(44606));
		repeat (12) @(posedge clk);
		@(negedge clk) rst_b = 1'b1;
		repeat (4) @(negedge clk);
		p(2'b01);
		s(24'h000010);
		init = 1'b1;
		s(24'h000070);
		p(2'b10);
		M.wr(16'h6040, 16'h0006);
		s(24'h000031);
		rel = 1'b1;
		M.wr(16'h6040, 16'h000f);
		s(24'h000031);
		M.wr(16'h6040, 16'h0006);
		rel = 1'b0;
		M.wr(16'h6040, 16'h000f);
		s(24'h000037);
		mov = 1'b1;
		comm = 1'b0;
		M.wr(16'h6040, 16'h0000);
		s(24'h81003f);
		mov = 1'b0;
		s(24'h810038);
		comm = 1'b1;
		M.wr(16'h6040, 16'h0000);
		M.wr(16'h6040, 16'h0080);
		s(24'h000070);
		M.wr(16'h6040, 16'h0006);
		M.wr(16'h6040, 16'h000f);
		M.wr(16'h6040, 16'h0002);
		s(24'h000017);
		mov = 1'b1;
		pwr = 1'b0;
		s(24'h23002f);
		mov = 1'b0;
		pwr = 1'b1;
		s(24'h230038);
		M.wr(16'h6040, 16'h0000);
		M.wr(16'h6040, 16'h0080);
		M.wr(16'h6040, 16'h0006);
		M.wr(16'h6040, 16'h000f);
		M.wr(16'h6040, 16'h0007);
		s(24'h000033);
		rel = 1'b1;
		s(24'h000031);
		M.wr(16'h6040, 16'h0006);
		rel = 1'b0;
		M.wr(16'h6040, 16'h000f);
		mov = 1'b1;
		rel = 1'b1;
		s(24'h000031);
		M.wr(16'h6040, 16'h0006);
		rel = 1'b0;
		mov = 1'b0;
		M.wr(16'h6041, 16'h0000);
		s(24'h000031);
		M.wr(16'h6040, 16'h0000);
		s(24'h000070);
		M.wr(16'h6040, 16'h0006);
		M.wr(16'h6040, 16'h000f);
		M.wr(16'h6040, 16'h0002);
		qsd = 1'b1;
		s(24'h000070);
		qsd = 1'b0;
		M.wr(16'h6040, 16'h0006);
		M.wr(16'h6040, 16'h000f);
		M.wr(16'h6040, 16'h0002);
		rel = 1'b1;
		s(24'h000070);
		end_of_test;
	end
endmodule // dsm_top_tb
bind dsm_top dsm_chk u_chk (.clk(clk), .rst_b(rst_b), .rd_addr(rd_addr), .rd_data(rd_data),
	.main_power(main_power), .param_wr(param_wr), .param_wr_ok(param_wr_ok),
	.param_wr_refused(param_wr_refused), .motor_excite(motor_excite), .stop_request(stop_request),
	.alarm_code(alarm_code), .status_word(status_word));
`default_nettype wire
